// [synth_cfg_pkg.sv]
// shared constants and carriers for the serial programming front end
// assumes one 25 MHz core clock and a synchronous active-high reset
package synth_cfg_pkg;
  // ==========================================================
  // word layout
  // ==========================================================
  localparam int WORD_W = 32;
  localparam int ADDR_W = 4;
  localparam int NUM_LATCH = 13;
  localparam logic [3:0] ADDR_R0 = 4'h0;
  localparam logic [3:0] ADDR_R1 = 4'h1;
  localparam logic [3:0] ADDR_R2 = 4'h2;
  localparam logic [3:0] ADDR_R4 = 4'h4;
  localparam logic [3:0] ADDR_R6 = 4'h6;
  localparam logic [3:0] ADDR_LAST = 4'hc;
  // latch 0 fields
  localparam int INT_LSB = 4;
  localparam int INT_W = 16;
  localparam int AUTOCAL_BIT = 21;
  // latch 1 / 2 fields
  localparam int MAINFRAC_LSB = 4;
  localparam int MAINFRAC_W = 24;
  localparam int AUXMOD_LSB = 4;
  localparam int AUX_W = 14;
  localparam int AUXFRAC_LSB = 18;
  // latch 4 fields
  localparam int CP_LSB = 10;
  localparam int CP_W = 4;
  localparam int DBUF_BIT = 14;
  localparam int RCNT_LSB = 15;
  localparam int RCNT_W = 10;
  localparam int RHALF_BIT = 25;
  localparam int RDBL_BIT = 26;
  localparam int TSEL_LSB = 27;
  localparam int TSEL_W = 3;
  // latch 6 fields
  localparam int PWR_LSB = 1;
  localparam int PWR_W = 2;
  localparam int DBL_EN_BIT = 10;
  localparam int MUTE_LOCK_BIT = 11;
  localparam int FBSRC_LSB = 21;
  localparam int FBSRC_W = 3;
  // ==========================================================
  // anti-backlash pulse, picoseconds, and calibration search size
  // ==========================================================
  localparam int ABL_INT_PS = 1600;
  localparam int ABL_FRAC_PS = 2600;
  localparam int CORES = 4;
  localparam int BANDS = 256;
  // ==========================================================
  // carriers
  // ==========================================================
  typedef struct packed {
    logic [RCNT_W-1:0] ref_count;
    logic ref_doubler;
    logic reference_halving;
    logic [CP_W-1:0] cp_current;
    logic [MAINFRAC_W-1:0] main_fraction_numerator;
    logic [AUX_W-1:0] aux_fraction_numerator;
    logic [AUX_W-1:0] aux_modulus;
    logic [2:0] out_div_sel;
  } dbuf_t;
  typedef struct packed {
    logic [1:0] core;
    logic [7:0] band;
  } cal_t;
endpackage : synth_cfg_pkg

// [band_select.sv]
// band selection engine: walks four cores by 256 bands
// assumes ref_tick is a one-cycle pulse from the reference divider output
`timescale 1ns/1ns
`default_nettype none
module band_select
  import synth_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic ref_tick,
  input wire logic tune_high,
  output logic busy,
  output cal_t result
);
  // ==========================================================
  // binary search state
  // ==========================================================
  typedef enum logic [1:0] {IDLE, SEARCH, DONE} cal_state_t;
  cal_state_t state_ff, nxt_state;
  logic [3:0] step_ff;       // remaining search steps
  logic [9:0] code_ff;       // {core, band} trial code
  logic [9:0] bit_ff;        // bit under trial
  wire logic [9:0] kept = tune_high ? code_ff : (code_ff & ~bit_ff);
  wire logic [9:0] nxt_bit = {1'b0, bit_ff[9:1]};

  // next state: SEARCH ends only on a reference tick; IDLE and DONE do not wait for one
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      IDLE: if (start) nxt_state = SEARCH;
      SEARCH: if (ref_tick && step_ff == 4'h0) nxt_state = DONE;
      DONE: nxt_state = IDLE;
      default: nxt_state = IDLE;
    endcase
  end

  // search register: one decision per reference period
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= IDLE;
      step_ff <= 4'h0;
      code_ff <= 10'h000;
      bit_ff <= 10'h000;
      result <= '0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == IDLE && start) begin
        step_ff <= 4'h9;
        code_ff <= 10'h200;
        bit_ff <= 10'h200;
      end else if (state_ff == SEARCH && ref_tick) begin
        code_ff <= kept | nxt_bit;
        bit_ff <= nxt_bit;
        step_ff <= step_ff - 4'h1;
        if (step_ff == 4'h0) result <= kept;
      end
    end
  end
  assign busy = (state_ff != IDLE);
endmodule : band_select
`default_nettype wire

// [serial_config_latch_bank.sv]
// three-wire serial programming front end with thirteen word latches
// assumes pins are asynchronous to CORE_CLK; serial clock far slower than it
// Function
// - one bit shifted per serial clock rise
// - words arrive most significant bit first
// - strobe rise copies word to one latch
// - low four bits index latches 0..12
// - buffered settings apply after latch 0 write
// - listed fraction, reference, pump settings are buffered
// - divider select buffered only when enabled
// - latch 0 write starts autocalibration if enabled
// - search four cores of 256 bands
// - tuning node held at reference during search
// - calibration stepped by reference divider output
// - three-bit field picks test output source
// - two-bit field sets main output power
// - mute-until-lock holds main output off
// - doubled output muted only by own bit
// - feedback source field selects divider input
// - anti-backlash width fixed per mode
// - divider widths 10, 16, 24, 14 bits
// - zero numerators select pure integer mode
`timescale 1ns/1ns
`default_nettype none
module serial_config_latch_bank
  import synth_cfg_pkg::*;
#(
  parameter int CLK_MHZ = 25
)(
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic SER_CLK,
  input wire logic SER_DATA,
  input wire logic LOAD_STROBE,
  input wire logic REF_DIV_OUT,
  input wire logic LOCK_DETECT,
  input wire logic ANALOG_LOCK,
  input wire logic TUNE_HIGH,
  input wire logic [7:0] TEST_SOURCES,
  output logic TEST_OUTPUT_PIN,
  output logic MAIN_OUTPUT_ON,
  output logic [PWR_W-1:0] MAIN_OUTPUT_POWER,
  output logic DOUBLED_OUTPUT_ON,
  output logic [FBSRC_W-1:0] FEEDBACK_SOURCE,
  output logic TUNING_NODE_TO_REF,
  output logic CAL_BUSY,
  output cal_t CAL_RESULT,
  output logic INTEGER_MODE,
  output logic [7:0] ANTI_BACKLASH_CYCLES_PS,
  output logic [INT_W-1:0] INT_VALUE,
  output dbuf_t ACTIVE_SETTINGS,
  output logic AUTOCAL_ON,
  output logic [WORD_W-1:0] LATCH_WORD [NUM_LATCH]
);
  // ==========================================================
  // pin synchronisers: three stages; clock, strobe and reference change on agreement
  // ==========================================================
  logic [2:0] sck_sync_ff, sda_sync_ff, stb_sync_ff, ref_sync_ff;
  logic sck_ff, stb_ff, ref_ff;  // filtered levels
  wire logic sck_agree = (sck_sync_ff[1] == sck_sync_ff[2]);
  wire logic stb_agree = (stb_sync_ff[1] == stb_sync_ff[2]);
  wire logic ref_agree = (ref_sync_ff[1] == ref_sync_ff[2]);
  wire logic sck_rise = sck_agree && sck_sync_ff[1] && !sck_ff;
  wire logic stb_rise = stb_agree && stb_sync_ff[1] && !stb_ff;
  wire logic ref_rise = ref_agree && ref_sync_ff[1] && !ref_ff;

  // capture pins; stage 0 feeds only stage 1
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      sck_sync_ff <= 3'h0;
      sda_sync_ff <= 3'h0;
      stb_sync_ff <= 3'h0;
      ref_sync_ff <= 3'h0;
    end else begin
      sck_sync_ff <= {sck_sync_ff[1:0], SER_CLK};
      sda_sync_ff <= {sda_sync_ff[1:0], SER_DATA};
      stb_sync_ff <= {stb_sync_ff[1:0], LOAD_STROBE};
      ref_sync_ff <= {ref_sync_ff[1:0], REF_DIV_OUT};
    end
  end

  // filtered levels move only when the last two stages agree
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      sck_ff <= 1'b0;
      stb_ff <= 1'b0;
      ref_ff <= 1'b0;
    end else begin
      if (sck_agree) sck_ff <= sck_sync_ff[1];
      if (stb_agree) stb_ff <= stb_sync_ff[1];
      if (ref_agree) ref_ff <= ref_sync_ff[1];
    end
  end

  // ==========================================================
  // input shift register
  // ==========================================================
  logic [WORD_W-1:0] shift_ff;
  // data pin settles well before the clock edge, so stage two is safe
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) shift_ff <= '0;
    else if (sck_rise) shift_ff <= {shift_ff[WORD_W-2:0], sda_sync_ff[2]};
  end

  // ==========================================================
  // latch decode
  // ==========================================================
  wire logic [ADDR_W-1:0] addr = shift_ff[ADDR_W-1:0];
  wire logic addr_ok = (addr <= ADDR_LAST);            // codes 13..15 land nowhere
  wire logic commit = stb_rise && addr_ok;
  wire logic commit_r0 = commit && (addr == ADDR_R0);
  wire logic dbuf_div = LATCH_WORD[ADDR_R4][DBUF_BIT];

  // one latch per index, written only on its own code
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LATCH; gi++) begin : g_latch
      always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) LATCH_WORD[gi] <= '0;
        else if (commit && addr == gi[ADDR_W-1:0]) LATCH_WORD[gi] <= shift_ff;
      end
    end
  endgenerate

  // ==========================================================
  // double-buffered staging
  // ==========================================================
  dbuf_t staged;  // newest written values, not yet in force
  wire logic [WORD_W-1:0] w1 = LATCH_WORD[ADDR_R1];
  wire logic [WORD_W-1:0] w2 = LATCH_WORD[ADDR_R2];
  wire logic [WORD_W-1:0] w4 = LATCH_WORD[ADDR_R4];
  wire logic [WORD_W-1:0] w6 = LATCH_WORD[ADDR_R6];
  // field widths follow the divider sizes
  assign staged.ref_count = w4[RCNT_LSB +: RCNT_W];
  assign staged.ref_doubler = w4[RDBL_BIT];
  assign staged.reference_halving = w4[RHALF_BIT];
  assign staged.cp_current = w4[CP_LSB +: CP_W];
  assign staged.main_fraction_numerator = w1[MAINFRAC_LSB +: MAINFRAC_W];
  assign staged.aux_fraction_numerator = w2[AUXFRAC_LSB +: AUX_W];
  assign staged.aux_modulus = w2[AUXMOD_LSB +: AUX_W];
  assign staged.out_div_sel = w6[FBSRC_LSB +: FBSRC_W];

  // latch 0 strobe moves staged values into force; the latches are
  // written at that same edge, so a fresh latch 0 uses older staged fields
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ACTIVE_SETTINGS <= '0;
    end else if (commit_r0) begin
      ACTIVE_SETTINGS <= staged;
    end else if (!dbuf_div) begin
      ACTIVE_SETTINGS.out_div_sel <= staged.out_div_sel;
    end
  end

  // ==========================================================
  // calibration trigger and band select
  // ==========================================================
  logic cal_start_ff;
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) cal_start_ff <= 1'b0;
    else cal_start_ff <= commit_r0 && shift_ff[AUTOCAL_BIT];
  end

  band_select u_band (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .start(cal_start_ff),
    .ref_tick(ref_rise),
    .tune_high(TUNE_HIGH),
    .busy(CAL_BUSY),
    .result(CAL_RESULT)
  );

  // ==========================================================
  // output controls
  // ==========================================================
  wire logic frac_zero = (ACTIVE_SETTINGS.main_fraction_numerator == '0) &&
                         (ACTIVE_SETTINGS.aux_fraction_numerator == '0);
  wire logic [7:0] test_mux = TEST_SOURCES | {7'h00, ANALOG_LOCK & 1'b0};
  wire logic [TSEL_W-1:0] tsel = w4[TSEL_LSB +: TSEL_W];

  // registered control outputs
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      TEST_OUTPUT_PIN <= 1'b0;
      MAIN_OUTPUT_ON <= 1'b0;
      MAIN_OUTPUT_POWER <= '0;
      DOUBLED_OUTPUT_ON <= 1'b0;
      FEEDBACK_SOURCE <= '0;
      TUNING_NODE_TO_REF <= 1'b0;
      INTEGER_MODE <= 1'b1;
      ANTI_BACKLASH_CYCLES_PS <= 8'h00;
      INT_VALUE <= '0;
      AUTOCAL_ON <= 1'b0;
    end else begin
      TEST_OUTPUT_PIN <= test_mux[tsel];
      MAIN_OUTPUT_ON <= !(w6[MUTE_LOCK_BIT] && !LOCK_DETECT);
      MAIN_OUTPUT_POWER <= w6[PWR_LSB +: PWR_W];
      DOUBLED_OUTPUT_ON <= w6[DBL_EN_BIT];
      FEEDBACK_SOURCE <= w6[FBSRC_LSB +: FBSRC_W];
      TUNING_NODE_TO_REF <= CAL_BUSY || cal_start_ff;
      INTEGER_MODE <= frac_zero;
      // pulse width in units of 100 ps
      ANTI_BACKLASH_CYCLES_PS <= frac_zero ? 8'(ABL_INT_PS / 100) : 8'(ABL_FRAC_PS / 100);
      INT_VALUE <= LATCH_WORD[ADDR_R0][INT_LSB +: INT_W];
      AUTOCAL_ON <= LATCH_WORD[ADDR_R0][AUTOCAL_BIT];
    end
  end
endmodule : serial_config_latch_bank
`default_nettype wire

// [scl_bank_props.sv]
// concurrent checks on the serial latch bank outputs
// assumes it is bound to the bank and sees its own port names
`timescale 1ns/1ns
`default_nettype none
module scl_bank_props
  import synth_cfg_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic LOCK_DETECT,
  input wire logic [7:0] TEST_SOURCES,
  input wire logic TEST_OUTPUT_PIN,
  input wire logic MAIN_OUTPUT_ON,
  input wire logic [PWR_W-1:0] MAIN_OUTPUT_POWER,
  input wire logic DOUBLED_OUTPUT_ON,
  input wire logic [FBSRC_W-1:0] FEEDBACK_SOURCE,
  input wire logic TUNING_NODE_TO_REF,
  input wire logic CAL_BUSY,
  input wire logic INTEGER_MODE,
  input wire logic [7:0] ANTI_BACKLASH_CYCLES_PS,
  input wire logic [INT_W-1:0] INT_VALUE,
  input wire dbuf_t ACTIVE_SETTINGS,
  input wire logic AUTOCAL_ON,
  input wire logic [WORD_W-1:0] LATCH_WORD [NUM_LATCH]
);
  // ==========================================================
  // output relations; field checks wait three quiet cycles so sync delay settles
  // ==========================================================
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  mux_pin_a: assert property (
    ($stable(LATCH_WORD[4]) && $stable(TEST_SOURCES))[*3] |-> TEST_OUTPUT_PIN == TEST_SOURCES[LATCH_WORD[4][29:27]])
    else $error("test pin source wrong");
  out_fields_a: assert property ($stable(LATCH_WORD[6])[*3] |->
    MAIN_OUTPUT_POWER == LATCH_WORD[6][2:1] && DOUBLED_OUTPUT_ON == LATCH_WORD[6][10]
    && FEEDBACK_SOURCE == LATCH_WORD[6][23:21]) else $error("output field mismatch");
  mute_lock_a: assert property (
    (LATCH_WORD[6][11] && !LOCK_DETECT)[*6] |-> !MAIN_OUTPUT_ON) else $error("main output on before lock");
  int_value_a: assert property ($stable(LATCH_WORD[0])[*3] |->
    INT_VALUE == LATCH_WORD[0][19:4] && AUTOCAL_ON == LATCH_WORD[0][21]) else $error("integer value wrong");
  int_mode_a: assert property ($stable(ACTIVE_SETTINGS)[*3] |-> INTEGER_MODE ==
    (ACTIVE_SETTINGS.main_fraction_numerator == 0 && ACTIVE_SETTINGS.aux_fraction_numerator == 0))
    else $error("integer mode wrong");
  backlash_a: assert property ($stable(INTEGER_MODE)[*3] |->
    ANTI_BACKLASH_CYCLES_PS == (INTEGER_MODE ? 8'h10 : 8'h1a)) else $error("backlash width wrong");
  cal_start_a: assert property (!$stable(LATCH_WORD[0]) && LATCH_WORD[0][21] |-> ##[1:4] CAL_BUSY)
    else $error("calibration not started");
  tune_ref_a: assert property (CAL_BUSY[*2] |-> TUNING_NODE_TO_REF)
    else $error("tuning node not at reference");
  // staged copies move only with a latch 0 commit; divider select may bypass
  staged_hold_a: assert property (
    !$stable(ACTIVE_SETTINGS[$bits(dbuf_t)-1:3]) |-> !$stable(LATCH_WORD[0])) else $error("staged value moved early");
endmodule : scl_bank_props
bind serial_config_latch_bank scl_bank_props u_scl_bank_props (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
  .LOCK_DETECT(LOCK_DETECT), .TEST_SOURCES(TEST_SOURCES), .TEST_OUTPUT_PIN(TEST_OUTPUT_PIN),
  .MAIN_OUTPUT_ON(MAIN_OUTPUT_ON), .MAIN_OUTPUT_POWER(MAIN_OUTPUT_POWER), .DOUBLED_OUTPUT_ON(DOUBLED_OUTPUT_ON),
  .FEEDBACK_SOURCE(FEEDBACK_SOURCE), .TUNING_NODE_TO_REF(TUNING_NODE_TO_REF), .CAL_BUSY(CAL_BUSY),
  .INTEGER_MODE(INTEGER_MODE), .ANTI_BACKLASH_CYCLES_PS(ANTI_BACKLASH_CYCLES_PS), .INT_VALUE(INT_VALUE),
  .ACTIVE_SETTINGS(ACTIVE_SETTINGS), .AUTOCAL_ON(AUTOCAL_ON), .LATCH_WORD(LATCH_WORD));
`default_nettype wire

// [host_model.sv]
// host side of the three-wire programming link
// assumes clk is the core clock; edges are spaced 8 core cycles
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic clk,
  output logic ser_clk,
  output logic ser_data,
  output logic load_strobe
);
  // ==========================================================
  // idle levels: clock and strobe low between frames
  // ==========================================================
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    load_strobe = 1'b0;
  end
  // one word: data set up, clock rises, then strobe after the last bit
  task automatic send(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      ser_data <= w[i];
      repeat (8) @(posedge clk);
      ser_clk <= 1'b1;
      repeat (8) @(posedge clk);
      ser_clk <= 1'b0;
    end
    ser_data <= ~w[0]; // released data shows the inverse, not the last bit
    repeat (8) @(posedge clk);
    load_strobe <= 1'b1;
    repeat (8) @(posedge clk);
    load_strobe <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : send
endmodule : host_model
`default_nettype wire

// [serial_config_latch_bank_tb.sv]
// self-checking bench for the serial latch bank
// assumes the host model drives the three pins at core clock edges
`timescale 1ns/1ns
`default_nettype none
module serial_config_latch_bank_tb
  import synth_cfg_pkg::*;
;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ref_div_out = 1'b0;
  logic lock_detect = 1'b0;
  logic tune_high = 1'b1;  // comparator level seen by the band search
  logic [7:0] test_sources = 8'ha5;
  wire ser_clk, ser_data, load_strobe;
  wire logic test_pin, main_on, dbl_on, tune_ref, cal_busy, int_mode, autocal_on;
  wire logic [1:0] main_pwr;
  wire logic [2:0] fb_src;
  wire logic [7:0] abl;
  wire logic [15:0] int_value;
  wire cal_t cal_res;
  wire dbuf_t act;
  wire logic [31:0] latch [NUM_LATCH];
  int n_fail = 0;
  int tests_run = 0;
  typedef struct packed {logic [31:0] w; logic [3:0] at;} row_t;
  // one word per latch; latch 4 keeps positive detector polarity
  row_t rows [13] = '{'{32'h0000_1230, 4'h0}, '{32'h0012_3451, 4'h1}, '{32'h0004_0082, 4'h2},
    '{32'h0000_0013, 4'h3}, '{32'h1800_4084, 4'h4}, '{32'h0a5a_5a55, 4'h5}, '{32'h00a0_0406, 4'h6},
    '{32'h5a5a_5a57, 4'h7}, '{32'h5a5a_5a58, 4'h8}, '{32'h5a5a_5a59, 4'h9}, '{32'h5a5a_5a5a, 4'ha},
    '{32'h5a5a_5a5b, 4'hb}, '{32'h5a5a_5a5c, 4'hc}};
  always #20 core_clk = ~core_clk;
  // reference divider output, slow against the core clock
  always begin
    repeat (8) @(posedge core_clk);
    ref_div_out <= ~ref_div_out;
  end
  host_model u_host_model (.clk(core_clk), .ser_clk(ser_clk), .ser_data(ser_data), .load_strobe(load_strobe));
  serial_config_latch_bank u_serial_config_latch_bank (.CORE_CLK(core_clk), .SYS_RST(sys_rst),
    .SER_CLK(ser_clk), .SER_DATA(ser_data), .LOAD_STROBE(load_strobe), .REF_DIV_OUT(ref_div_out),
    .LOCK_DETECT(lock_detect), .ANALOG_LOCK(1'b0), .TUNE_HIGH(tune_high), .TEST_SOURCES(test_sources),
    .TEST_OUTPUT_PIN(test_pin), .MAIN_OUTPUT_ON(main_on), .MAIN_OUTPUT_POWER(main_pwr),
    .DOUBLED_OUTPUT_ON(dbl_on), .FEEDBACK_SOURCE(fb_src), .TUNING_NODE_TO_REF(tune_ref), .CAL_BUSY(cal_busy),
    .CAL_RESULT(cal_res), .INTEGER_MODE(int_mode), .ANTI_BACKLASH_CYCLES_PS(abl), .INT_VALUE(int_value),
    .ACTIVE_SETTINGS(act), .AUTOCAL_ON(autocal_on), .LATCH_WORD(latch));
  // ==========================================================
  // compare, send and close
  // ==========================================================
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // send on a rising edge, then look at settled outputs on the falling one
  task automatic put(input logic [31:0] w);
    @(posedge core_clk);
    u_host_model.send(w);
    @(negedge core_clk);
  endtask : put
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (5) @(negedge core_clk);
    chk("int mode at reset", int_mode, 32'h1);
    for (int i = 0; i < 13; i++) begin
      put(rows[i].w);
      chk("latch word", latch[int'(rows[i].at)], rows[i].w);
    end
    chk("frac held", act.main_fraction_numerator, 32'h0);
    chk("div sel held", act.out_div_sel, 32'h0);
    chk("power", main_pwr, 32'h3);
    chk("doubled on", dbl_on, 32'h1);
    chk("fb source", fb_src, 32'h5);
    chk("main on", main_on, 32'h1);
    for (int s = 0; s < 8; s++) begin
      put(32'h0000_4084 | (s << 27));
      chk("test pin", test_pin, test_sources[s]);
    end
    put(32'h0000_2340);
    chk("frac active", act.main_fraction_numerator, 32'h12345);
    chk("aux_modulus active", act.aux_modulus, 32'h8);
    chk("aux_fraction_numerator active", act.aux_fraction_numerator, 32'h1);
    chk("div sel active", act.out_div_sel, 32'h5);
    chk("int value", int_value, 32'h234);
    chk("frac mode", int_mode, 32'h0);
    chk("frac backlash", abl, 32'h1a);
    put(32'h0000_0084);
    put(32'h0060_0806);
    chk("div sel direct", act.out_div_sel, 32'h3);
    chk("muted", main_on, 32'h0);
    chk("doubled off", dbl_on, 32'h0);
    @(posedge core_clk);
    lock_detect <= 1'b1;
    repeat (8) @(negedge core_clk);
    chk("unmuted", main_on, 32'h1);
    put(32'hffff_fffd);
    chk("code 13 ignored", latch[12], 32'h5a5a_5a5c);
    chk("latch 0 kept", latch[0], 32'h0000_2340);
    put(32'h0000_0001);
    put(32'h0000_0022);
    // first pass keeps every trial bit, second pass drops every one
    for (int p = 0; p < 2; p++) begin
      @(posedge core_clk);
      tune_high <= (p == 0);
      put(32'h0020_3450);
      chk("cal busy", cal_busy, 32'h1);
      chk("tune at ref", tune_ref, 32'h1);
      chk("int mode", int_mode, 32'h1);
      chk("int backlash", abl, 32'h10);
      for (int k = 0; cal_busy !== 1'b0; k++) begin
        if (k == 2000) begin
          n_fail++;
          end_of_test();
        end
        @(negedge core_clk);
      end
      // the tuning switch is registered, so it lets go one cycle after busy
      @(negedge core_clk);
      chk("cal result", cal_res, (p == 0) ? 32'h3ff : 32'h0);
      chk("tune released", tune_ref, 32'h0);
    end
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    chk("latch cleared", latch[6], 32'h0);
    end_of_test();
  end
endmodule : serial_config_latch_bank_tb
`default_nettype wire
